//--- core/cfp_reader.sv
// Reader end: Avalon-MM command registers and contact sequencer
`timescale 1ns/1ps
`include "cfp_regs.svh"
`default_nettype none
module cfp_reader
  import cfp_pkg::*;
#(
  parameter int PROG_HIGH_CYCLES = `CFP_PROG_CYC,
  parameter int HALF_CYCLES = `CFP_HALF_CYC
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Avalon-MM slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Contacts to the card
  cfp_link_if.reader link
);

  // ==========================================================
  // Local signals
  cfp_state_t state;
  logic [19:0] tmr;
  logic [11:0] steps;
  logic [`CFP_ADDR_W-1:0] tgt;
  logic prog_op;
  logic ec_done;
  logic refused;
  logic io_meta;
  logic io_sync;
  logic cmd_wr;
  logic iss_req;
  logic accept;
  logic refuse;
  logic fin;

  // ==========================================================
  // Command decode; a write lands at the waitrequest-low edge
  assign cmd_wr = avs_write && !avs_waitrequest
                  && (avs_address == `CFP_CMD_OFS);
  assign iss_req = avs_writedata[`CFP_CMD_PROG_BIT]
    && (avs_writedata[10:0] >= `CFP_ISS_LO)
    && (avs_writedata[10:0] <= `CFP_ISS_HI);
  // Issuer blow before the erase-counter blow is refused
  assign refuse = cmd_wr && (state == CFP_IDLE) && iss_req
                  && !ec_done; // RULE3
  assign accept = cmd_wr && (state == CFP_IDLE) && !refuse;
  assign fin = (state == CFP_FIN) && (tmr == 20'h00000);

  // ==========================================================
  // Bus handshake: one wait cycle, then the answer
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'h1;
    end else if ((avs_read || avs_write) && avs_waitrequest) begin
      avs_waitrequest <= 1'h0;
    end else begin
      avs_waitrequest <= 1'h1;
    end
  end

  // Read data; unmapped offsets read zero
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      avs_readdata <= 32'h0;
    end else if (avs_read && avs_waitrequest) begin
      avs_readdata <= 32'h0;
      if (avs_address == `CFP_CMD_OFS) begin
        avs_readdata[10:0] <= tgt;
        avs_readdata[`CFP_CMD_FUS_BIT] <= link.personalize_pin;
        avs_readdata[`CFP_CMD_PROG_BIT] <= prog_op;
      end else if (avs_address == `CFP_STAT_OFS) begin
        avs_readdata[`CFP_ST_BUSY] <= (state != CFP_IDLE);
        avs_readdata[`CFP_ST_REFUSED] <= refused;
        avs_readdata[`CFP_ST_EC_DONE] <= ec_done;
        avs_readdata[`CFP_ST_IO] <= io_sync;
      end
    end
  end

  // ==========================================================
  // Status: refusal and erase-counter-fuse progress
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      refused <= 1'h0;
      ec_done <= 1'h0;
    end else begin
      if (refuse) begin
        refused <= 1'h1;
      end else if (accept) begin
        refused <= 1'h0;
      end
      if (fin && prog_op && link.personalize_pin
          && tgt == `CFP_EC_ADDR) begin
        ec_done <= 1'h1; // RULE3
      end
    end
  end

  // Data contact crossing from the card
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      io_meta <= 1'h1;
      io_sync <= 1'h1;
    end else begin
      io_meta <= link.io_level;
      io_sync <= io_meta;
    end
  end

  // ==========================================================
  // Contact sequencer; card clock comes from this divider.
  // In reset the clock toggles so the card can reset too.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state <= CFP_IDLE;
      tmr <= 20'h00000;
      steps <= 12'h000;
      tgt <= '0;
      prog_op <= 1'h0;
      // Written as a test so an unknown start still toggles
      if (link.card_clk) begin
        link.card_clk <= 1'h0;
      end else begin
        link.card_clk <= 1'h1;
      end
      link.addr_clr <= 1'h0;
      link.prog <= 1'h0;
      link.personalize_pin <= 1'h0;
    end else if (state == CFP_IDLE) begin
      link.card_clk <= 1'h0;
      if (accept) begin
        tgt <= avs_writedata[10:0];
        prog_op <= avs_writedata[`CFP_CMD_PROG_BIT];
        link.personalize_pin <= avs_writedata[`CFP_CMD_FUS_BIT];
        link.addr_clr <= 1'h1;
        tmr <= 20'(HALF_CYCLES - 1);
        state <= CFP_CLRA;
      end
    end else if (tmr != 20'h00000) begin
      tmr <= tmr - 20'h00001;
    end else begin
      tmr <= 20'(HALF_CYCLES - 1);
      case (state)
        CFP_CLRA: begin
          link.card_clk <= 1'h1;
          state <= CFP_CLRB;
        end
        CFP_CLRB: begin
          link.card_clk <= 1'h0;
          state <= CFP_CLRC;
        end
        CFP_CLRC: begin
          // Release with clock low; next edge lands at zero
          link.addr_clr <= 1'h0; // RULE7
          steps <= {1'h0, tgt} + 12'h001;
          state <= CFP_STPL;
        end
        CFP_STPL: begin
          if (steps == 12'h000) begin
            if (prog_op) begin
              link.addr_clr <= 1'h1;
              link.prog <= 1'h1;
              tmr <= 20'(`CFP_SETUP_CYC - 1);
              state <= CFP_ARM;
            end else begin
              state <= CFP_IDLE;
            end
          end else begin
            link.card_clk <= 1'h1;
            state <= CFP_STPH;
          end
        end
        CFP_STPH: begin
          link.card_clk <= 1'h0;
          steps <= steps - 12'h001;
          state <= CFP_STPL;
        end
        CFP_ARM: begin
          link.card_clk <= 1'h1;
          tmr <= 20'(PROG_HIGH_CYCLES - 1); // RULE12
          state <= CFP_PROG;
        end
        CFP_PROG: begin
          // Program pin falls before the clock does
          link.prog <= 1'h0;
          state <= CFP_PEND;
        end
        CFP_PEND: begin
          link.card_clk <= 1'h0;
          state <= CFP_REL;
        end
        CFP_REL: begin
          link.addr_clr <= 1'h0; // RULE7
          state <= CFP_FIN;
        end
        CFP_FIN: begin
          state <= CFP_IDLE;
        end
        default: begin
          state <= CFP_IDLE;
        end
      endcase
    end
  end

endmodule : cfp_reader
`default_nettype wire

//--- core/cfp_regs.svh
// Constants for the card fuse personalization link and reader registers
`ifndef CFP_REGS_SVH
`define CFP_REGS_SVH

// ==========================================================
// Card address map
`define CFP_ADDR_W 11
`define CFP_MFR_LO 11'h5B0
`define CFP_MFR_HI 11'h5BF
`define CFP_EC_ADDR 11'h5F9
`define CFP_ISS_LO 11'h610
`define CFP_ISS_HI 11'h61F
`define CFP_FUSE_INTACT 1'h1

// ==========================================================
// Reader register map (byte offsets) and fields
`define CFP_CMD_OFS 4'h0
`define CFP_STAT_OFS 4'h4
`define CFP_CMD_ADDR_LSB 0
`define CFP_CMD_FUS_BIT 16
`define CFP_CMD_PROG_BIT 17
`define CFP_ST_BUSY 0
`define CFP_ST_REFUSED 1
`define CFP_ST_EC_DONE 2
`define CFP_ST_IO 3

// ==========================================================
// Timing, in ns, and derived core cycles
`define CFP_CORE_NS 5
`define CFP_HALF_CLK_NS 1650
`define CFP_PGM_SETUP_NS 2200
`define CFP_PROG_HIGH_NS 3000000
`define CFP_HALF_CYC ((`CFP_HALF_CLK_NS + `CFP_CORE_NS - 1) / `CFP_CORE_NS)
`define CFP_SETUP_CYC ((`CFP_PGM_SETUP_NS + `CFP_CORE_NS - 1) / `CFP_CORE_NS)
`define CFP_PROG_CYC ((`CFP_PROG_HIGH_NS + `CFP_CORE_NS - 1) / `CFP_CORE_NS)

`endif

//--- core/cfp_pkg.sv
// Types shared by the card and reader ends
package cfp_pkg;
  // Reader sequencer states, one-hot
  typedef enum logic [10:0] {
    CFP_IDLE = 11'h001,
    CFP_CLRA = 11'h002,
    CFP_CLRB = 11'h004,
    CFP_CLRC = 11'h008,
    CFP_STPL = 11'h010,
    CFP_STPH = 11'h020,
    CFP_ARM  = 11'h040,
    CFP_PROG = 11'h080,
    CFP_PEND = 11'h100,
    CFP_REL  = 11'h200,
    CFP_FIN  = 11'h400
  } cfp_state_t;
endpackage : cfp_pkg

//--- core/cfp_link_if.sv
// Contact-level link between reader and card
`timescale 1ns/1ps
`default_nettype none
interface cfp_link_if;
  logic card_clk;
  logic addr_clr;
  logic prog;
  logic personalize_pin;
  logic io_out;
  logic io_drive_n;
  logic io_level;

  // Open drain with external pull-up
  assign io_level = io_drive_n ? 1'h1 : io_out;

  modport card (
    input card_clk, addr_clr, prog, personalize_pin, io_level,
    output io_out, io_drive_n
  );
  modport reader (
    output card_clk, addr_clr, prog, personalize_pin,
    input io_level
  );
endinterface : cfp_link_if
`default_nettype wire

//--- core/cfp_card.sv
// Card end: address counter, fuses and security level logic
// Operation
// RULE1: Manufacturer fuse blows in range 1456-1471
// RULE2: Erase-counter enable fuse blows at 1529
// RULE3: Reader blows erase-counter fuse before issuer
// RULE4: Issuer fuse blows in range 1552-1567
// RULE5: Blown issuer fuse means permanent high security
// RULE6: Counter frozen while address-clear is high
// RULE7: Releasing address-clear, clock low, zeroes counter
// RULE8: Personalization needs personalize pin high
// RULE9: Low personalize pin mimics high security
// RULE10: After issuer blow personalize pin ignored
// RULE11: Pin low with address-clear high: standby
// RULE12: Reader holds clock high 3.0 ms programming
// RULE13: Validated flag comes from security code check
// RULE14: Any other write leaves fuses unchanged
`timescale 1ns/1ps
`include "cfp_regs.svh"
`default_nettype none
module cfp_card
  import cfp_pkg::*;
(
  // Contacts from the reader
  cfp_link_if.card link,
  // Card power-on reset, synchronous to the card clock
  input wire logic rst_n,
  // Flag from the security code check, other domain
  input wire logic code_validated_flag,
  // Fuse states, 0 = blown
  output logic mfr_fuse,
  output logic erase_counter_enable_fuse,
  output logic issuer_fuse,
  // Access state
  output logic high_security,
  output logic personalize_ok,
  output logic standby,
  output logic [`CFP_ADDR_W-1:0] bit_addr
);

  // ==========================================================
  // Local signals
  logic valid_meta;
  logic valid_sync;
  logic clr_pending;
  logic [`CFP_ADDR_W-1:0] next_bit_addr;
  logic lvl2;
  logic in_mfr;
  logic in_iss;
  logic at_ec;
  logic fuse_write;
  logic blow_mfr;
  logic blow_ec;
  logic blow_iss;
  logic standby_now;
  logic restricted_now;
  logic read_bit;

  // ==========================================================
  // Fuse value seen at a bit address; 1 outside fuse cells
  function automatic logic fuse_at(
    input logic [`CFP_ADDR_W-1:0] a,
    input logic mf,
    input logic ec,
    input logic is
  );
    logic r;
    r = 1'h1;
    if (a >= `CFP_MFR_LO && a <= `CFP_MFR_HI) begin
      r = mf;
    end else if (a == `CFP_EC_ADDR) begin
      r = ec;
    end else if (a >= `CFP_ISS_LO && a <= `CFP_ISS_HI) begin
      r = is;
    end
    return r;
  endfunction : fuse_at

  // ==========================================================
  // Validated flag crossing into the card clock domain
  // Two stages; only the second is read by logic
  always_ff @(posedge link.card_clk) begin
    if (!rst_n) begin
      valid_meta <= 1'h0;
      valid_sync <= 1'h0;
    end else begin
      valid_meta <= code_validated_flag;
      valid_sync <= valid_meta; // RULE13
    end
  end

  // ==========================================================
  // Decode of the current position and pin state
  assign lvl2 = (issuer_fuse != `CFP_FUSE_INTACT);
  assign in_mfr = (bit_addr >= `CFP_MFR_LO) && (bit_addr <= `CFP_MFR_HI);
  assign in_iss = (bit_addr >= `CFP_ISS_LO) && (bit_addr <= `CFP_ISS_HI);
  assign at_ec = (bit_addr == `CFP_EC_ADDR);
  // A fuse write is a program edge with address-clear held high
  assign fuse_write = link.prog && link.addr_clr;

  // Pin only matters while the issuer fuse is intact
  assign standby_now = !lvl2 && link.addr_clr
                       && !link.personalize_pin; // RULE11 RULE10
  assign restricted_now = lvl2 || !link.personalize_pin; // RULE9 RULE10

  // ==========================================================
  // Fuse blow qualifiers; anything else leaves the fuses alone
  // Manufacturer: lower level, validated, pin level free
  assign blow_mfr = fuse_write && !lvl2 && valid_sync
                    && in_mfr; // RULE1 RULE14
  // Erase-counter enable: lower level only, pin must be high;
  // once the issuer fuse is blown it can never be set
  assign blow_ec = fuse_write && !lvl2 && link.personalize_pin
                   && at_ec; // RULE2 RULE3 RULE14
  // Issuer: validated, pin level free (overrides standby)
  assign blow_iss = fuse_write && valid_sync && in_iss; // RULE4 RULE14

  // ==========================================================
  // Next counter value: frozen under address-clear, zeroed on
  // the first edge after release, else one step per read edge
  always_comb begin
    next_bit_addr = bit_addr;
    if (link.addr_clr) begin
      next_bit_addr = bit_addr; // RULE6
    end else if (clr_pending) begin
      next_bit_addr = '0; // RULE7
    end else if (!link.prog) begin
      next_bit_addr = bit_addr + 11'h001;
    end
  end

  // ==========================================================
  // Bit address counter
  // A write edge (program high) never advances the counter
  always_ff @(posedge link.card_clk) begin
    if (!rst_n) begin
      bit_addr <= '0;
    end else begin
      bit_addr <= next_bit_addr; // RULE6
    end
  end

  // ==========================================================
  // Pending clear: the clock is stopped when address-clear
  // falls, so the zeroing lands on the next edge instead
  always_ff @(posedge link.card_clk) begin
    if (!rst_n) begin
      clr_pending <= 1'h1;
    end else if (link.addr_clr) begin
      clr_pending <= 1'h1; // RULE7
    end else begin
      clr_pending <= 1'h0;
    end
  end

  // ==========================================================
  // Manufacturer fuse; a blown fuse never returns to 1
  always_ff @(posedge link.card_clk) begin
    if (!rst_n) begin
      mfr_fuse <= `CFP_FUSE_INTACT;
    end else if (blow_mfr) begin
      mfr_fuse <= 1'h0; // RULE1
    end
  end

  // ==========================================================
  // Erase-counter enable fuse
  always_ff @(posedge link.card_clk) begin
    if (!rst_n) begin
      erase_counter_enable_fuse <= `CFP_FUSE_INTACT;
    end else if (blow_ec) begin
      erase_counter_enable_fuse <= 1'h0; // RULE2
    end
  end

  // ==========================================================
  // Issuer fuse: one-way, so the higher level is permanent
  always_ff @(posedge link.card_clk) begin
    if (!rst_n) begin
      issuer_fuse <= `CFP_FUSE_INTACT;
    end else if (blow_iss) begin
      issuer_fuse <= 1'h0; // RULE4 RULE5
    end
  end

  // ==========================================================
  // Effective access level, refreshed every card clock edge
  // High security follows the fuse with no way back
  always_ff @(posedge link.card_clk) begin
    if (!rst_n) begin
      high_security <= 1'h0;
    end else begin
      high_security <= restricted_now || blow_iss; // RULE5 RULE9
    end
  end

  // ==========================================================
  // Personalization writes and erases allowed only with pin
  // high, issuer fuse intact and not in standby
  always_ff @(posedge link.card_clk) begin
    if (!rst_n) begin
      personalize_ok <= 1'h0;
    end else begin
      personalize_ok <= !restricted_now && !standby_now
                        && !blow_iss; // RULE8 RULE10
    end
  end

  // ==========================================================
  // Standby indication
  always_ff @(posedge link.card_clk) begin
    if (!rst_n) begin
      standby <= 1'h0;
    end else begin
      standby <= standby_now; // RULE11
    end
  end

  // ==========================================================
  // Data contact: the fuse bit at the new address is shown on
  // the open-drain output; released in standby and while
  // programming so it never fights the reader
  assign read_bit = fuse_at(next_bit_addr, mfr_fuse,
                            erase_counter_enable_fuse, issuer_fuse);
  always_ff @(posedge link.card_clk) begin
    if (!rst_n) begin
      link.io_drive_n <= 1'h1;
    end else if (standby_now || link.prog || link.addr_clr) begin
      link.io_drive_n <= 1'h1; // RULE11
    end else begin
      link.io_drive_n <= read_bit;
    end
  end

  // Open drain only ever pulls low
  assign link.io_out = 1'h0;

endmodule : cfp_card
`default_nettype wire

//--- verif/cfp_link_props.sv
// Checker for the reader-card link and the reader bus handshake
`timescale 1ns/1ps
`include "cfp_regs.svh"
`default_nettype none
module cfp_link_props (
  // Clocks and shared reset
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic card_clk,
  // Contacts driven by the reader, then the card's data drive
  input wire logic addr_clr,
  input wire logic prog,
  input wire logic personalize_pin,
  input wire logic io_drive_n,
  // Card inputs and state
  input wire logic code_validated_flag,
  input wire logic mfr_fuse,
  input wire logic erase_counter_enable_fuse,
  input wire logic issuer_fuse,
  input wire logic high_security,
  input wire logic personalize_ok,
  input wire logic standby,
  input wire logic [`CFP_ADDR_W-1:0] bit_addr,
  // Reader bus handshake
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest
);
  // ==========================================================
  // Sequences
  // A fuse write edge: program and address clear both high
  sequence fuse_write;
    prog && addr_clr;
  endsequence
  sequence bus_req;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  // Slave answers next cycle and the low level stands one cycle only
  sequence one_ack;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence

  // ==========================================================
  // Card counter and fuses
  frozen_counter_a: assert property (@(posedge card_clk)
    disable iff (!rst_n) addr_clr |=> $stable(bit_addr))
    else $error("counter moved while clear high");
  clear_release_a: assert property (@(posedge card_clk)
    disable iff (!rst_n) $fell(addr_clr) |=> bit_addr == 11'h000)
    else $error("counter not zero after clear release");
  // The card sees the flag two card edges late, past its synchroniser
  mfr_blow_a: assert property (@(posedge card_clk)
    disable iff (!rst_n) fuse_write ##0 ($past(code_validated_flag, 2) &&
    issuer_fuse && bit_addr inside {[`CFP_MFR_LO:`CFP_MFR_HI]})
    |=> !mfr_fuse) else $error("maker fuse not blown");
  ec_blow_a: assert property (@(posedge card_clk)
    disable iff (!rst_n) fuse_write ##0 (personalize_pin && issuer_fuse
    && bit_addr == `CFP_EC_ADDR) |=> !erase_counter_enable_fuse)
    else $error("erase counter fuse not blown");
  iss_blow_a: assert property (@(posedge card_clk)
    disable iff (!rst_n) fuse_write ##0 ($past(code_validated_flag, 2) &&
    bit_addr inside {[`CFP_ISS_LO:`CFP_ISS_HI]}) |=> !issuer_fuse)
    else $error("issuer fuse not blown");
  // Any edge that is not a fuse write in a fuse range leaves fuses alone
  fuse_hold_a: assert property (@(posedge card_clk)
    disable iff (!rst_n) !(prog && addr_clr && (bit_addr inside
    {[`CFP_MFR_LO:`CFP_MFR_HI], `CFP_EC_ADDR, [`CFP_ISS_LO:`CFP_ISS_HI]}))
    |=> $stable({mfr_fuse, erase_counter_enable_fuse, issuer_fuse}))
    else $error("fuse changed without a valid write");

  // ==========================================================
  // Security level and access
  high_level_a: assert property (@(posedge card_clk)
    disable iff (!rst_n) (!issuer_fuse || !personalize_pin)
    |=> high_security) else $error("high level not in force");
  low_level_a: assert property (@(posedge card_clk)
    disable iff (!rst_n) issuer_fuse && personalize_pin && !prog
    |=> !high_security) else $error("high level without cause");
  no_personal_a: assert property (@(posedge card_clk)
    disable iff (!rst_n) (!issuer_fuse || !personalize_pin)
    |=> !personalize_ok) else $error("personalization wrongly open");
  standby_a: assert property (@(posedge card_clk)
    disable iff (!rst_n) issuer_fuse && addr_clr && !personalize_pin
    && !prog |=> standby && io_drive_n) else $error("standby not entered");

  // ==========================================================
  // Reader bus
  bus_answer_a: assert property (@(posedge core_clk)
    disable iff (!rst_n) bus_req |=> one_ack)
    else $error("waitrequest answer off");
endmodule : cfp_link_props
`default_nettype wire

//--- verif/tb_top.sv
// Self-checking bench joining the reader and card ends
`timescale 1ns/1ps
`include "cfp_regs.svh"
`default_nettype none
module tb_top;
  // ==========================================================
  // Signals
  logic core_clk, rst_n, avs_read, avs_write, avs_waitrequest;
  logic [3:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, q, r, last_status;
  logic code_validated_flag, mfr_fuse, erase_counter_enable_fuse;
  logic issuer_fuse, high_security, personalize_ok, standby;
  logic [10:0] bit_addr, tgt;
  int seed, n_errors, checks_done;

  cfp_link_if i_cfp_link_if ();
  // Card clock half period of eight core cycles gives an 80 ns period
  cfp_reader #(.PROG_HIGH_CYCLES(20), .HALF_CYCLES(8)) i_cfp_reader (
    .core_clk(core_clk),
    .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .link(i_cfp_link_if));
  cfp_card i_cfp_card (.link(i_cfp_link_if), .rst_n(rst_n),
    .code_validated_flag(code_validated_flag), .mfr_fuse(mfr_fuse),
    .erase_counter_enable_fuse(erase_counter_enable_fuse),
    .issuer_fuse(issuer_fuse), .high_security(high_security),
    .personalize_ok(personalize_ok), .standby(standby),
    .bit_addr(bit_addr));
  cfp_link_props i_cfp_link_props (.core_clk(core_clk), .rst_n(rst_n),
    .card_clk(i_cfp_link_if.card_clk), .addr_clr(i_cfp_link_if.addr_clr),
    .prog(i_cfp_link_if.prog),
    .personalize_pin(i_cfp_link_if.personalize_pin),
    .io_drive_n(i_cfp_link_if.io_drive_n),
    .code_validated_flag(code_validated_flag), .mfr_fuse(mfr_fuse),
    .erase_counter_enable_fuse(erase_counter_enable_fuse),
    .issuer_fuse(issuer_fuse), .high_security(high_security),
    .personalize_ok(personalize_ok), .standby(standby),
    .bit_addr(bit_addr), .avs_read(avs_read), .avs_write(avs_write),
    .avs_waitrequest(avs_waitrequest));

  // ==========================================================
  // Expectations and bus tasks
  function automatic logic [31:0] cmd_word(input logic [10:0] a,
                                           input logic pin, input logic pg);
    return {14'h0000, pg, pin, 5'h00, a};
  endfunction : cmd_word
  function automatic logic exp_high(input logic iss, input logic pin);
    return !iss || !pin;
  endfunction : exp_high
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h, want %h", $time, seen, exp);
    end
  endtask : chk
  // Entered just after a rising edge; the request stands until the edge
  // at which waitrequest is sampled low, and read data is taken there
  task automatic bus(input logic wr, input logic [3:0] adr,
                     input logic [31:0] d, output logic [31:0] rd);
    int n;
    n = 0;
    avs_address <= adr;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'h0 && n < 50);
    chk(n < 50, 1'h1);
    rd = avs_readdata;
    avs_write <= 1'h0;
    avs_read <= 1'h0;
    // One idle edge so a following call never re-raises in this step
    @(posedge core_clk);
  endtask : bus
  task automatic go(input logic [10:0] a, input logic pin, input logic pg);
    bus(1'h1, `CFP_CMD_OFS, cmd_word(a, pin, pg), q);
  endtask : go
  // Poll sparsely: a fuse positioning takes about 25k core cycles
  task automatic cmd(input logic [10:0] a, input logic pin, input logic pg);
    int n;
    if (pg !== 1'hX) go(a, pin, pg);
    n = 0;
    do begin
      repeat (40) @(posedge core_clk);
      bus(1'h0, `CFP_STAT_OFS, 32'h0, last_status);
      n++;
    end while (last_status[`CFP_ST_BUSY] !== 1'h0 && n < 1000);
    chk(n < 1000, 1'h1);
    chk({i_cfp_link_if.card_clk, i_cfp_link_if.addr_clr}, 2'h0);
  endtask : cmd
  task automatic wrap_up();
    if (n_errors == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : wrap_up

  // ==========================================================
  // Clock and watchdog
  initial begin
    core_clk = 1'h0;
    forever #2.5 core_clk = ~core_clk;
  end
  // Three fuse orders run, about 25k cycles each; 100k cycles is ample
  initial begin
    #500_000;
    chk(1'h0, 1'h1);
    wrap_up();
  end

  // ==========================================================
  // Main sequence
  initial begin
    rst_n = 1'h0;
    avs_address = 4'h0;
    avs_read = 1'h0;
    avs_write = 1'h0;
    avs_writedata = 32'h0;
    code_validated_flag = 1'h0;
    seed = 53630;
    n_errors = 0;
    checks_done = 0;
    // Six edges give the card three clock pulses for its own reset
    repeat (6) @(posedge core_clk);
    rst_n <= 1'h1;
    repeat (2) @(posedge core_clk);
    chk({mfr_fuse, erase_counter_enable_fuse, issuer_fuse}, 3'h7);
    chk(bit_addr, 11'h000);
    bus(1'h0, 4'h8, 32'h0, q);
    chk(q, 32'h0);
    // Positioning with random pin; a second order while busy is dropped
    for (int i = 0; i < 3; i++) begin
      r = $random(seed);
      tgt = 11'h002 + {6'h00, r[4:0]};
      go(tgt, r[8], 1'h0);
      if (i == 0) go(11'h000, 1'h1, 1'h0);
      cmd(tgt, r[8], 1'hX);
      chk(bit_addr, tgt);
      chk(high_security, exp_high(1'h1, r[8]));
      chk(personalize_ok, r[8]);
      chk(i_cfp_link_if.io_level, 1'h1);
      chk(last_status[`CFP_ST_IO], 1'h1);
      bus(1'h0, `CFP_CMD_OFS, 32'h0, q);
      chk(q, cmd_word(tgt, r[8], 1'h0));
    end
    // Program outside every fuse range, with and without validation
    for (int f = 0; f < 2; f++) begin
      r = $random(seed);
      code_validated_flag <= f[0];
      tgt = 11'h004 + {8'h00, r[2:0]};
      cmd(tgt, r[5], 1'h1);
      chk({mfr_fuse, erase_counter_enable_fuse, issuer_fuse}, 3'h7);
      chk(bit_addr, tgt);
    end
    // Issuer blow before the erase-counter blow is turned away
    r = $random(seed);
    cmd(`CFP_ISS_LO + {7'h00, r[3:0]}, 1'h1, 1'h1);
    chk(last_status[`CFP_ST_REFUSED], 1'h1);
    chk(issuer_fuse, 1'h1);
    // Maker fuse with the pin low
    tgt = `CFP_MFR_LO + {7'h00, r[7:4]};
    cmd(tgt, 1'h0, 1'h1);
    chk(mfr_fuse, 1'h0);
    chk({erase_counter_enable_fuse, issuer_fuse}, 2'h3);
    chk(bit_addr, tgt);
    chk(standby, 1'h1);
    cmd(`CFP_EC_ADDR, 1'h1, 1'h1);
    chk(erase_counter_enable_fuse, 1'h0);
    chk(last_status[`CFP_ST_EC_DONE], 1'h1);
    chk(issuer_fuse, 1'h1);
    cmd(`CFP_ISS_LO + {7'h00, r[11:8]}, r[12], 1'h1);
    chk(issuer_fuse, 1'h0);
    chk(high_security, 1'h1);
    // Pin high no longer opens anything once the issuer fuse is gone
    cmd(11'h003, 1'h1, 1'h0);
    chk(high_security, exp_high(1'h0, 1'h1));
    chk(personalize_ok, 1'h0);
    chk({mfr_fuse, erase_counter_enable_fuse, issuer_fuse}, 3'h0);
    wrap_up();
  end
endmodule : tb_top
`default_nettype wire
